// ### src/scio_top.sv
// Current reduction timers, tuning settings and configurable I/O of the drive
//
// Summary of operation
// - Stop timeout expiry cuts current by 25 percent
// - Next commanded step restores full current
// - Stop timeout in ms, 0 to 19656
// - Stop timeout zero disables stop reduction
// - Idle timeout in seconds, reduces by percentage
// - Idle timeout zero disables idle reduction
// - Idle percentage whole number 0 to 100
// - Idle percentage overrides 25 when both enabled
// - Primary damping gain 0..32767, zero disables
// - Secondary damping gain 0.1 to 25.0
// - Smoothing gain 20..2621, maximum turns off
// - Multistep enabled holds smoothing gain fixed
// - Stall detector works only at or above 0.5 rps
// - Four inputs, one output, selectable functions
// - Jog inputs move; speed input picks high
// - Stop input decelerates at the stop rate
// - Abort input halts motion without ramp
// - Travel limit also serves as home reference
// - Undefined or reserved codes do nothing
// - Move select inputs form binary move number
// - Brake output asserts on drive fault
// - Moving output while stepping or engine busy
// - Stall output follows stall detector report
// - Each input and output has selectable polarity
// - Move select debounced by restartable scan timer
`timescale 1ns/10ps

module scio_top #(
	parameter int          MS_CYCLES         = scio_pkg::TICK_MS_NS / scio_pkg::CLK_PERIOD_NS,
	parameter logic [11:0] SMOOTH_FIXED_GAIN = 12'h064,
	parameter int          NUM_IN            = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rdata,
	input  wire logic        step_pin,
	input  wire logic [3:0]  din_pin,
	input  wire logic        engine_busy,
	input  wire logic        drive_fault,
	input  wire logic        stall_report,
	input  wire logic [11:0] motor_velocity,
	output logic             dout_pin,
	output logic      [6:0]  current_pct,
	output logic             damping_enable,
	output logic      [14:0] damping_gain_primary,
	output logic      [7:0]  damping_gain_secondary,
	output logic             smoothing_filter_enable,
	output logic      [11:0] smoothing_filter_gain,
	output logic             encoderless_stall_detector,
	output logic             jog_fwd,
	output logic             jog_rev,
	output logic             jog_high_speed,
	output logic             stop_request,
	output logic             abort_request,
	output logic             travel_limit_input,
	output logic             home_reference,
	output logic             warm_boot,
	output logic      [3:0]  profile_index,
	output logic             profile_start
);

	// Prescaler width wide enough for one millisecond
	localparam int PRE_W = $clog2(MS_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);
	localparam logic [9:0] SEC_LAST = 10'(scio_pkg::MS_PER_S - 1);

	// Whole state of the block
	typedef struct packed {
		logic [scio_pkg::CTRL_W-1:0] ctrl;        // Feature enables
		logic [14:0]                 stop_tmo;    // Stop timeout, ms
		logic [11:0]                 idle_tmo;    // Idle timeout, s
		logic [6:0]                  idle_pct;    // Idle reduction, percent
		logic [14:0]                 gain_pri;    // Primary damping gain
		logic [7:0]                  gain_sec;    // Secondary gain, tenths
		logic [11:0]                 smooth;      // Smoothing gain setting
		logic [15:0]                 in_func;     // Four 4-bit input codes
		logic [2:0]                  out_func;    // Output code
		logic [4:0]                  pol;         // 1 = active high
		logic [14:0]                 scan_tmo;    // Scan time, ms
		logic [2:0]                  step_sync;   // Step pin synchroniser
		logic                        step_lvl;    // Filtered step level
		logic [3:0]                  din_s1;      // Input sync stage 1
		logic [3:0]                  din_s2;      // Input sync stage 2
		logic [3:0]                  din_s3;      // Input sync stage 3
		logic [3:0]                  din_lvl;     // Filtered input levels
		logic [PRE_W-1:0]            ms_pre;      // Reduction ms prescaler
		logic [14:0]                 stop_cnt;    // ms since last step
		logic [9:0]                  ms_in_sec;   // ms within the second
		logic [11:0]                 idle_cnt;    // s since last step
		logic                        act;         // Step in this ms
		logic                        act_prev;    // Step in previous ms
		logic [PRE_W-1:0]            scan_pre;    // Scan ms prescaler
		logic [14:0]                 scan_cnt;    // ms the index is stable
		logic [3:0]                  idx_last;    // Last sampled index
		logic                        scan_armed;  // Start still pending
		logic                        start;       // Start pulse
		logic [6:0]                  current;     // Commanded current
		logic [13:0]                 io_out;      // Registered I/O decode
		logic [3:0]                  idx_out;     // Registered index
		logic [31:0]                 rdata;       // Read answer
	} scio_state_t;

	scio_state_t st;       // Registered state
	scio_state_t next_st;  // Next state

	// Limit a written value to its legal range
	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if (v < lo)
			r = lo;
		if (v > hi)
			r = hi;
		return r;
	endfunction : clamp

	// Asserted level of a pin under its polarity
	function automatic logic asserted(input logic lvl, input logic pol_high);
		return pol_high ? lvl : ~lvl;
	endfunction : asserted

	// Combinational helpers
	logic        step_evt;      // Rising edge of the filtered step
	logic        ms_tick;       // End of a reduction millisecond
	logic        stop_exp;      // Stop timeout elapsed
	logic        idle_exp;      // Idle timeout elapsed
	logic [6:0]  red_pct;       // Active reduction
	logic [3:0]  in_on;         // Inputs asserted after polarity
	logic [3:0]  idx;           // Move number from select inputs
	logic        f_jf;          // Function levels gathered over inputs
	logic        f_jr;
	logic        f_js;
	logic        f_stop;
	logic        f_abort;
	logic        f_lim;
	logic        f_boot;
	logic        moving;        // Steps or engine active
	logic        stall_active;  // Stall detector allowed to run
	logic        out_on;        // Output function asserted
	logic [31:0] rd_val;        // Selected read value

	// Next-state logic
	always_comb
	begin
		int k;
		k = 0;
		next_st = st;
		idx = 4'h0;
		f_jf = 1'b0;
		f_jr = 1'b0;
		f_js = 1'b0;
		f_stop = 1'b0;
		f_abort = 1'b0;
		f_lim = 1'b0;
		f_boot = 1'b0;
		out_on = 1'b0;
		rd_val = 32'h0000_0000;

		// Three-stage pin synchronisers, change taken when stages 2 and 3 agree
		next_st.step_sync = {st.step_sync[1:0], step_pin};
		if (st.step_sync[1] == st.step_sync[2])
			next_st.step_lvl = st.step_sync[2];
		next_st.din_s1 = din_pin;
		next_st.din_s2 = st.din_s1;
		next_st.din_s3 = st.din_s2;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (st.din_s2[i] == st.din_s3[i])
				next_st.din_lvl[i] = st.din_s3[i];
		end
		step_evt = next_st.step_lvl & ~st.step_lvl;

		// Register writes, values limited to their legal ranges
		if (wr_en)
		begin
			unique case (addr)
				scio_pkg::OFF_CTRL:
					next_st.ctrl = wdata[scio_pkg::CTRL_W-1:0];
				scio_pkg::OFF_STOP_TMO:
					next_st.stop_tmo = 15'(clamp(wdata, 32'h0, scio_pkg::STOP_TMO_MAX_MS));
				scio_pkg::OFF_IDLE_TMO:
					next_st.idle_tmo = 12'(clamp(wdata, 32'h0, scio_pkg::IDLE_TMO_MAX_S));
				scio_pkg::OFF_IDLE_PCT:
					next_st.idle_pct = 7'(clamp(wdata, 32'h0, scio_pkg::IDLE_PCT_MAX));
				scio_pkg::OFF_DAMP_PRI:
					next_st.gain_pri = 15'(clamp(wdata, 32'h0, scio_pkg::DAMP_PRI_MAX));
				scio_pkg::OFF_DAMP_SEC:
					next_st.gain_sec = 8'(clamp(wdata, scio_pkg::DAMP_SEC_MIN,
						scio_pkg::DAMP_SEC_MAX));
				scio_pkg::OFF_SMOOTH:
					next_st.smooth = 12'(clamp(wdata, scio_pkg::SMOOTH_MIN, scio_pkg::SMOOTH_MAX));
				scio_pkg::OFF_IN_FUNC:
					next_st.in_func = wdata[15:0];
				scio_pkg::OFF_OUT_FUNC:
					next_st.out_func = wdata[2:0];
				scio_pkg::OFF_POLARITY:
					next_st.pol = wdata[4:0];
				scio_pkg::OFF_SCAN_TMO:
					next_st.scan_tmo = 15'(clamp(wdata, 32'h0, scio_pkg::SCAN_TMO_MAX_MS));
				default:
					next_st.ctrl = st.ctrl; // Unmapped or read-only, ignored
			endcase
		end

		// Millisecond prescaler for the reduction timers
		ms_tick = (st.ms_pre == PRE_LAST);
		next_st.ms_pre = ms_tick ? '0 : st.ms_pre + 1'b1;
		if (ms_tick)
		begin
			// Stop and idle counters saturate at their largest timeout
			if (32'(st.stop_cnt) < scio_pkg::STOP_TMO_MAX_MS)
				next_st.stop_cnt = st.stop_cnt + 1'b1;
			next_st.ms_in_sec = (st.ms_in_sec == SEC_LAST) ? 10'h000 : st.ms_in_sec + 1'b1;
			if (st.ms_in_sec == SEC_LAST && 32'(st.idle_cnt) < scio_pkg::IDLE_TMO_MAX_S)
				next_st.idle_cnt = st.idle_cnt + 1'b1;
			// Activity window slides one ms
			next_st.act_prev = st.act;
			next_st.act = 1'b0;
		end
		if (step_evt)
		begin
			next_st.ms_pre = '0;
			next_st.stop_cnt = 15'h0000;
			next_st.ms_in_sec = 10'h000;
			next_st.idle_cnt = 12'h000;
			next_st.act = 1'b1;  // A step in the same tick wins
		end

		stop_exp = (st.stop_tmo != 15'h0000) && (next_st.stop_cnt >= st.stop_tmo);
		idle_exp = (st.idle_tmo != 12'h000) && (next_st.idle_cnt >= st.idle_tmo);

		// idle expiry applies the idle percentage
		if (idle_exp)
			red_pct = st.idle_pct;
		// idle percentage replaces the 25 percent
		else if (stop_exp && st.idle_tmo != 12'h000)
			red_pct = st.idle_pct;
		else if (stop_exp)
			red_pct = scio_pkg::STOP_RED_PCT;
		else
			red_pct = 7'h00;
		// a step clears the counters, so full current returns at once
		next_st.current = scio_pkg::FULL_PCT - red_pct;

		for (int i = 0; i < NUM_IN; i++)
			in_on[i] = asserted(st.din_lvl[i], st.pol[i]);

		// Function decode; reserved and undefined codes fall through idle
		for (int i = 0; i < NUM_IN; i++)
		begin
			unique case (st.in_func[4*i +: 4])
				scio_pkg::IN_JOG_FWD:
					f_jf = f_jf | in_on[i];
				scio_pkg::IN_JOG_REV:
					f_jr = f_jr | in_on[i];
				scio_pkg::IN_JOG_SPD:
					f_js = f_js | in_on[i];
				scio_pkg::IN_STOP:
					f_stop = f_stop | in_on[i];
				scio_pkg::IN_ABORT:
					f_abort = f_abort | in_on[i];
				scio_pkg::IN_LIMIT:
					f_lim = f_lim | in_on[i];
				// next index bit in input order
				scio_pkg::IN_MOVE_SEL:
				begin
					idx[k[1:0]] = in_on[i];
					k = k + 1;
				end
				scio_pkg::IN_REBOOT:
					f_boot = f_boot | in_on[i];
				default:
					f_boot = f_boot;
			endcase
		end

		// scan timer restarts on any index change
		next_st.idx_last = idx;
		next_st.start = 1'b0;
		if (idx != st.idx_last)
		begin
			next_st.scan_pre = '0;
			next_st.scan_cnt = 15'h0000;
			next_st.scan_armed = 1'b1;
		end
		else if (st.scan_armed)
		begin
			if (st.scan_cnt >= st.scan_tmo)
			begin
				// Stable for the whole scan time, launch once for a nonzero index
				next_st.start = (idx != 4'h0);
				next_st.scan_armed = 1'b0;
			end
			else if (st.scan_pre == PRE_LAST)
			begin
				next_st.scan_pre = '0;
				next_st.scan_cnt = st.scan_cnt + 1'b1;
			end
			else
				next_st.scan_pre = st.scan_pre + 1'b1;
		end
		next_st.idx_out = st.idx_last;

		// steps in the last window or engine busy
		moving = st.act | st.act_prev | engine_busy;
		// detector only at or above the velocity floor
		stall_active = st.ctrl[scio_pkg::CTRL_STALL_EN] && (motor_velocity >= scio_pkg::STALL_MIN_VEL);

		unique case (st.out_func)
			scio_pkg::OUT_BRAKE:
				out_on = drive_fault;
			scio_pkg::OUT_MOVING:
				out_on = moving;
			scio_pkg::OUT_STALL:
				out_on = stall_active & stall_report;
			default:
				out_on = 1'b0;
		endcase

		// Registered I/O outputs; output polarity is bit 4
		next_st.io_out = {f_jf, f_jr, f_js, f_stop, f_abort, f_lim, f_lim, f_boot,
			asserted(out_on, st.pol[4]), stall_active, moving, stop_exp, idle_exp, 1'b0};

		// Read mux; read data only in the cycle after the strobe
		unique case (addr)
			scio_pkg::OFF_CTRL:     rd_val = 32'(st.ctrl);
			scio_pkg::OFF_STOP_TMO: rd_val = 32'(st.stop_tmo);
			scio_pkg::OFF_IDLE_TMO: rd_val = 32'(st.idle_tmo);
			scio_pkg::OFF_IDLE_PCT: rd_val = 32'(st.idle_pct);
			scio_pkg::OFF_DAMP_PRI: rd_val = 32'(st.gain_pri);
			scio_pkg::OFF_DAMP_SEC: rd_val = 32'(st.gain_sec);
			scio_pkg::OFF_SMOOTH:   rd_val = 32'(st.smooth);
			scio_pkg::OFF_IN_FUNC:  rd_val = 32'(st.in_func);
			scio_pkg::OFF_OUT_FUNC: rd_val = 32'(st.out_func);
			scio_pkg::OFF_POLARITY: rd_val = 32'(st.pol);
			scio_pkg::OFF_SCAN_TMO: rd_val = 32'(st.scan_tmo);
			scio_pkg::OFF_STATUS:
				rd_val = {8'h00, st.idx_out, st.din_lvl, st.current, st.io_out[5:1], 4'h0};
			default:                rd_val = 32'h0000_0000;
		endcase
		next_st.rdata = rd_en ? rd_val : 32'h0000_0000;
	end

	// State register, synchronous active-low reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			st <= '0;
			st.gain_sec <= scio_pkg::DAMP_SEC_RST;
			st.smooth <= scio_pkg::SMOOTH_RST;
			st.pol <= scio_pkg::POL_RST;
			st.current <= scio_pkg::FULL_PCT;
		end
		else
			st <= next_st;
	end

	// Outputs straight from state
	assign rdata = st.rdata;
	assign current_pct = st.current;
	assign damping_enable = (st.gain_pri != 15'h0000);
	assign damping_gain_primary = st.gain_pri;
	assign damping_gain_secondary = st.gain_sec;
	assign smoothing_filter_gain = st.ctrl[scio_pkg::CTRL_MULTI_EN] ? SMOOTH_FIXED_GAIN : st.smooth;
	// top gain value leaves the filter off
	assign smoothing_filter_enable = st.ctrl[scio_pkg::CTRL_SMOOTH_EN]
		&& (32'(smoothing_filter_gain) != scio_pkg::SMOOTH_MAX);
	assign encoderless_stall_detector = st.io_out[4];
	assign jog_fwd = st.io_out[13];
	assign jog_rev = st.io_out[12];
	assign jog_high_speed = st.io_out[11];
	assign stop_request = st.io_out[10];
	assign abort_request = st.io_out[9];
	assign travel_limit_input = st.io_out[8];
	assign home_reference = st.io_out[7];
	assign warm_boot = st.io_out[6];
	assign dout_pin = st.io_out[5];
	assign profile_index = st.idx_out;
	assign profile_start = st.start;

endmodule : scio_top

// ### src/scio_pkg.sv
// Shared constants for the stepper current and machine I/O logic
package scio_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL       = 8'h00;
	localparam logic [7:0] OFF_STOP_TMO   = 8'h04;
	localparam logic [7:0] OFF_IDLE_TMO   = 8'h08;
	localparam logic [7:0] OFF_IDLE_PCT   = 8'h0c;
	localparam logic [7:0] OFF_DAMP_PRI   = 8'h10;
	localparam logic [7:0] OFF_DAMP_SEC   = 8'h14;
	localparam logic [7:0] OFF_SMOOTH     = 8'h18;
	localparam logic [7:0] OFF_IN_FUNC    = 8'h1c;
	localparam logic [7:0] OFF_OUT_FUNC   = 8'h20;
	localparam logic [7:0] OFF_POLARITY   = 8'h24;
	localparam logic [7:0] OFF_SCAN_TMO   = 8'h28;
	localparam logic [7:0] OFF_STATUS     = 8'h2c;

	// Control register bit positions
	localparam int CTRL_STALL_EN  = 0;
	localparam int CTRL_MULTI_EN  = 1;
	localparam int CTRL_SMOOTH_EN = 2;
	localparam int CTRL_W         = 3;

	// Value ranges
	localparam logic [31:0] STOP_TMO_MAX_MS = 32'h0000_4cc8; // 19656 ms
	localparam logic [31:0] IDLE_TMO_MAX_S  = 32'h0000_0e10; // 3600 s
	localparam logic [31:0] IDLE_PCT_MAX    = 32'h0000_0064; // 100 %
	localparam logic [31:0] DAMP_PRI_MAX    = 32'h0000_7fff; // 32767
	localparam logic [31:0] DAMP_SEC_MIN    = 32'h0000_0001; // 0.1 in tenths
	localparam logic [31:0] DAMP_SEC_MAX    = 32'h0000_00fa; // 25.0 in tenths
	localparam logic [31:0] SMOOTH_MIN      = 32'h0000_0014; // 20
	localparam logic [31:0] SMOOTH_MAX      = 32'h0000_0a3d; // 2621, filter off
	localparam logic [31:0] SCAN_TMO_MAX_MS = 32'h0000_4ccc; // 19660 ms

	// Current levels in percent
	localparam logic [6:0] FULL_PCT     = 7'h64;
	localparam logic [6:0] STOP_RED_PCT = 7'h19;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_MS_NS    = 1000000;
	localparam int MS_PER_S      = 1000;

	// Stall detector floor, velocity in tenths of a revolution per second
	localparam logic [11:0] STALL_MIN_VEL = 12'h005;

	// Input function codes
	localparam logic [3:0] IN_UNDEF    = 4'h0;
	localparam logic [3:0] IN_JOG_FWD  = 4'h1;
	localparam logic [3:0] IN_JOG_REV  = 4'h2;
	localparam logic [3:0] IN_JOG_SPD  = 4'h3;
	localparam logic [3:0] IN_STOP     = 4'h4;
	localparam logic [3:0] IN_ABORT    = 4'h5;
	localparam logic [3:0] IN_LIMIT    = 4'h6;
	localparam logic [3:0] IN_RSVD     = 4'h7;
	localparam logic [3:0] IN_MOVE_SEL = 4'h8;
	localparam logic [3:0] IN_REBOOT   = 4'h9;

	// Output function codes
	localparam logic [2:0] OUT_UNDEF  = 3'h0;
	localparam logic [2:0] OUT_BRAKE  = 3'h1;
	localparam logic [2:0] OUT_MOVING = 3'h2;
	localparam logic [2:0] OUT_RSVD   = 3'h3;
	localparam logic [2:0] OUT_STALL  = 3'h4;

	// Reset values
	localparam logic [7:0]  DAMP_SEC_RST = 8'h01;
	localparam logic [11:0] SMOOTH_RST   = 12'ha3d;
	localparam logic [4:0]  POL_RST      = 5'h00;

endpackage : scio_pkg

// ### verif/scio_props.sv
// Concurrent checks on the current, tuning and I/O ports of the drive
`timescale 1ns/10ps

module scio_props (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [6:0]  current_pct,
	input wire logic        damping_enable,
	input wire logic [14:0] damping_gain_primary,
	input wire logic [7:0]  damping_gain_secondary,
	input wire logic        smoothing_filter_enable,
	input wire logic [11:0] smoothing_filter_gain,
	input wire logic        encoderless_stall_detector,
	input wire logic [11:0] motor_velocity,
	input wire logic        travel_limit_input,
	input wire logic        home_reference,
	input wire logic        profile_start
);
	// One clock domain, so one default clocking and reset
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_damp_on: assert property (
		damping_enable == (damping_gain_primary != 15'h0000))
		else $error("damping enable disagrees with primary gain");
	a_sec_range: assert property (
		damping_gain_secondary >= 8'h01 && damping_gain_secondary <= 8'hfa)
		else $error("secondary gain out of range");
	a_smooth_range: assert property (
		smoothing_filter_gain >= 12'h014 && smoothing_filter_gain <= 12'ha3d)
		else $error("smoothing gain out of range");
	a_smooth_off: assert property (
		smoothing_filter_gain == 12'ha3d |-> !smoothing_filter_enable)
		else $error("smoothing on at maximum gain");
	a_pct_ceiling: assert property (
		current_pct <= 7'h64)
		else $error("current above full");
	// Detector output is registered, so the floor is checked one edge back
	a_stall_floor: assert property (
		encoderless_stall_detector |-> $past(motor_velocity) >= 12'h005)
		else $error("stall detector active below floor");
	a_home_limit: assert property (
		home_reference == travel_limit_input)
		else $error("home reference differs from travel limit");
	a_start_once: assert property (
		profile_start |=> !profile_start)
		else $error("profile start longer than one cycle");
endmodule : scio_props

// ### verif/scio_step_model.sv
// Step source standing in for the host pulse generator
`timescale 1ns/10ps

module scio_step_model (
	input wire logic ref_clk,
	input wire logic step_go,
	output logic     step_pin
);
	logic [3:0] cnt = 4'h0; // Cycles left in the current pulse

	// Six high then six low, long enough for the pin filter to agree
	always @(posedge ref_clk)
	begin
		if (step_go)
			cnt <= 4'hc;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end

	// Line idles low between pulses
	assign step_pin = (cnt > 4'h6);
endmodule : scio_step_model

// ### verif/tb_top.sv
// Self-checking bench for the drive current and I/O logic
`timescale 1ns/10ps

module tb_top;
	localparam int MSC = 10; // Short millisecond keeps the run brief
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic        step_go = 1'b0;
	logic [3:0]  din_pin = 4'h0;
	logic        engine_busy = 1'b0, drive_fault = 1'b0, stall_report = 1'b0;
	logic [11:0] motor_velocity = 12'h000;
	logic [31:0] rdata;
	logic        step_pin, dout_pin, damping_enable, smoothing_filter_enable;
	logic        encoderless_stall_detector, jog_fwd, jog_rev, jog_high_speed;
	logic        stop_request, abort_request, travel_limit_input, home_reference;
	logic        warm_boot, profile_start;
	logic [6:0]  current_pct;
	logic [14:0] damping_gain_primary;
	logic [7:0]  damping_gain_secondary;
	logic [11:0] smoothing_filter_gain;
	logic [3:0]  profile_index;
	int          n_mismatch = 0, checks_done = 0, n_start = 0;
	int          seed = 32'h47215cdc;
	logic [31:0] mdl [0:10]; // Register model, indexed by word
	logic [31:0] got, v;
	logic [7:0]  exp_in;

	always #10 ref_clk = ~ref_clk;

	scio_top #(.MS_CYCLES(MSC)) dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .step_pin(step_pin),
		.din_pin(din_pin), .engine_busy(engine_busy), .drive_fault(drive_fault),
		.stall_report(stall_report), .motor_velocity(motor_velocity),
		.dout_pin(dout_pin), .current_pct(current_pct), .damping_enable(damping_enable),
		.damping_gain_primary(damping_gain_primary),
		.damping_gain_secondary(damping_gain_secondary),
		.smoothing_filter_enable(smoothing_filter_enable),
		.smoothing_filter_gain(smoothing_filter_gain),
		.encoderless_stall_detector(encoderless_stall_detector),
		.jog_fwd(jog_fwd), .jog_rev(jog_rev), .jog_high_speed(jog_high_speed),
		.stop_request(stop_request), .abort_request(abort_request),
		.travel_limit_input(travel_limit_input), .home_reference(home_reference),
		.warm_boot(warm_boot), .profile_index(profile_index),
		.profile_start(profile_start));

	scio_step_model u_step (.ref_clk(ref_clk), .step_go(step_go), .step_pin(step_pin));

	// Count move starts as they happen
	always @(posedge ref_clk)
	begin
		if (profile_start === 1'b1)
			n_start <= n_start + 1;
	end

	// Clamp a written value to the range the register accepts
	function automatic logic [31:0] lim(input int i, input logic [31:0] x);
		logic [31:0] lo, hi;
		lo = 32'h0;
		hi = 32'hffff_ffff;
		case (i)
			1: hi = scio_pkg::STOP_TMO_MAX_MS;
			2: hi = scio_pkg::IDLE_TMO_MAX_S;
			3: hi = scio_pkg::IDLE_PCT_MAX;
			4: hi = scio_pkg::DAMP_PRI_MAX;
			5: begin lo = scio_pkg::DAMP_SEC_MIN; hi = scio_pkg::DAMP_SEC_MAX; end
			6: begin lo = scio_pkg::SMOOTH_MIN; hi = scio_pkg::SMOOTH_MAX; end
			10: hi = scio_pkg::SCAN_TMO_MAX_MS;
			default: ;
		endcase
		return (x < lo) ? lo : ((x > hi) ? hi : x);
	endfunction : lim

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// One-cycle write, model follows
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		if (a < 8'h2c)
			mdl[a >> 2] = lim(a >> 2, d);
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rdchk(input logic [7:0] a);
		logic [31:0] d;
		rd(a, d);
		chk("register", (a < 8'h2c) ? mdl[a >> 2] : 32'h0, d);
	endtask : rdchk

	task automatic step();
		@(posedge ref_clk);
		step_go <= 1'b1;
		@(posedge ref_clk);
		step_go <= 1'b0;
	endtask : step

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// Hang guard, well beyond the planned run length
	initial
	begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		foreach (mdl[i]) mdl[i] = 32'h0;
		mdl[5] = scio_pkg::DAMP_SEC_RST;
		mdl[6] = scio_pkg::SMOOTH_RST;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 11; i++) rdchk(8'(i * 4));
		rdchk(8'h40); // unmapped reads zero
		cyc(60);
		chk("current", 32'd100, current_pct);
		$display("test reset and disabled timers done");
		wr(scio_pkg::OFF_STOP_TMO, 32'h5000);
		rdchk(scio_pkg::OFF_STOP_TMO);
		wr(scio_pkg::OFF_STOP_TMO, 32'h2);
		cyc(60);
		chk("current", 32'd75, current_pct);
		step();
		cyc(12);
		chk("current", 32'd100, current_pct);
		wr(scio_pkg::OFF_IDLE_PCT, 32'd200);
		rdchk(scio_pkg::OFF_IDLE_PCT);
		wr(scio_pkg::OFF_IDLE_PCT, 32'd40);
		wr(scio_pkg::OFF_IDLE_TMO, 32'h1);
		cyc(60);
		chk("current", 32'd60, current_pct);
		wr(scio_pkg::OFF_STOP_TMO, 32'h0);
		step();
		cyc(9000);
		chk("current", 32'd100, current_pct);
		cyc(1200);
		chk("current", 32'd60, current_pct);
		step();
		cyc(12);
		chk("current", 32'd100, current_pct);
		$display("test current reduction done");
		repeat (4)
		begin
			v = $random(seed);
			wr(scio_pkg::OFF_DAMP_PRI, v);
			cyc(2);
			chk("pri gain", mdl[4], damping_gain_primary);
			chk("damp en", 32'(mdl[4] != 0), damping_enable);
		end
		wr(scio_pkg::OFF_DAMP_PRI, 32'h0);
		wr(scio_pkg::OFF_DAMP_SEC, 32'h0);
		cyc(2);
		chk("damp en", 32'h0, damping_enable);
		chk("sec gain", 32'h1, damping_gain_secondary);
		wr(scio_pkg::OFF_DAMP_SEC, 32'd300);
		rdchk(scio_pkg::OFF_DAMP_SEC);
		wr(scio_pkg::OFF_SMOOTH, 32'h10);
		rdchk(scio_pkg::OFF_SMOOTH);
		wr(scio_pkg::OFF_CTRL, 32'h4);
		wr(scio_pkg::OFF_SMOOTH, 32'ha3d);
		cyc(2);
		chk("smooth en", 32'h0, smoothing_filter_enable);
		wr(scio_pkg::OFF_SMOOTH, 32'd500);
		cyc(2);
		chk("smooth en", 32'h1, smoothing_filter_enable);
		wr(scio_pkg::OFF_CTRL, 32'h6);
		cyc(2);
		chk("smooth gain", 32'h64, smoothing_filter_gain);
		wr(scio_pkg::OFF_CTRL, 32'h1);
		motor_velocity <= 12'h004;
		cyc(4);
		chk("stall det", 32'h0, encoderless_stall_detector);
		motor_velocity <= 12'h005;
		cyc(4);
		chk("stall det", 32'h1, encoderless_stall_detector);
		$display("test gains and stall detector done");
		wr(scio_pkg::OFF_POLARITY, 32'h1f);
		for (int c = 0; c < 16; c++)
		begin
			wr(scio_pkg::OFF_IN_FUNC, 32'(c));
			din_pin <= 4'h1;
			cyc(10);
			exp_in = {c == 1, c == 2, c == 3, c == 4, c == 5, c == 6, c == 6, c == 9};
			got = {jog_fwd, jog_rev, jog_high_speed, stop_request, abort_request,
				travel_limit_input, home_reference, warm_boot};
			chk("input funcs", exp_in, got);
			if (c == 8)
			begin
				chk("index", 32'h1, profile_index);
				chk("starts", 32'h1, n_start);
			end
			din_pin <= 4'h0;
			cyc(10);
		end
		// Scan time debounce: a change 15 cycles into the 2 ms wait restarts the wait
		wr(scio_pkg::OFF_SCAN_TMO, 32'h5000);
		rdchk(scio_pkg::OFF_SCAN_TMO);
		wr(scio_pkg::OFF_SCAN_TMO, 32'h2);
		wr(scio_pkg::OFF_IN_FUNC, 32'h88);
		din_pin <= 4'h1;
		cyc(15);
		din_pin <= 4'h3;
		cyc(15);
		chk("starts", 32'h1, n_start);
		cyc(20);
		chk("starts", 32'h2, n_start);
		chk("index", 32'h3, profile_index);
		wr(scio_pkg::OFF_POLARITY, 32'h0);
		wr(scio_pkg::OFF_IN_FUNC, 32'h1);
		din_pin <= 4'he;
		cyc(10);
		chk("low jog", 32'h1, jog_fwd);
		din_pin <= 4'hf;
		cyc(10);
		chk("low jog", 32'h0, jog_fwd);
		$display("test input functions done");
		motor_velocity <= 12'h00a;
		wr(scio_pkg::OFF_POLARITY, 32'h10);
		for (int c = 0; c < 5; c++)
		begin
			wr(scio_pkg::OFF_OUT_FUNC, 32'(c));
			for (int s = 0; s < 2; s++)
			begin
				drive_fault  <= s[0];
				engine_busy  <= s[0];
				stall_report <= s[0];
				cyc(60);
				chk("dout", 32'(s == 1 && (c == 1 || c == 2 || c == 4)), dout_pin);
			end
		end
		$display("test output functions done");
		end_sim();
	end
endmodule : tb_top

bind scio_top scio_props u_props (
	.ref_clk(ref_clk), .rst_b(rst_b), .current_pct(current_pct),
	.damping_enable(damping_enable), .damping_gain_primary(damping_gain_primary),
	.damping_gain_secondary(damping_gain_secondary),
	.smoothing_filter_enable(smoothing_filter_enable),
	.smoothing_filter_gain(smoothing_filter_gain),
	.encoderless_stall_detector(encoderless_stall_detector),
	.motor_velocity(motor_velocity), .travel_limit_input(travel_limit_input),
	.home_reference(home_reference), .profile_start(profile_start));
